// ==== pdc_pll_divider_config.sv ====
// Purpose: Register file and counters of the synthesizer reference and feedback dividers
// Assumes: ref_tick and osc_tick are one-cycle events synchronous to clk
// Notes: Feedback ratio is P*B + A with A swallowed from B in dual-modulus modes; registers written by byte

`timescale 1ns/100ps

module pdc_pll_divider_config (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Clock events
   input wire logic ref_tick,
   input wire logic osc_tick,
   // Divider outputs
   output logic ref_div_tick,
   output logic prescaler_tick,
   output logic fb_div_tick,
   // Status and analog controls
   output logic charge_pump_output_half,
   output logic ref_div_held,
   output logic fb_div_held,
   output logic fixed_divide_mode,
   output logic dual_modulus_mode
);

   // Register storage
   logic [7:0] ref_low;
   logic [5:0] ref_high;
   logic [5:0] swallow_count;
   logic [7:0] main_count_low;
   logic [4:0] main_count_high;
   pdc_pkg::pdc_ctrl_t divider_control;

   // Write decode
   logic wr_ref_low;
   logic wr_ref_high;
   logic wr_swallow;
   logic wr_main_low;
   logic wr_main_high;
   logic wr_ctrl;
   logic [7:0] rd_mux;

   assign wr_ref_low = reg_wr && (reg_addr == pdc_pkg::ADDR_REF_LOW);
   assign wr_ref_high = reg_wr && (reg_addr == pdc_pkg::ADDR_REF_HIGH);
   assign wr_swallow = reg_wr && (reg_addr == pdc_pkg::ADDR_SWALLOW);
   assign wr_main_low = reg_wr && (reg_addr == pdc_pkg::ADDR_MAIN_LOW);
   assign wr_main_high = reg_wr && (reg_addr == pdc_pkg::ADDR_MAIN_HIGH);
   assign wr_ctrl = reg_wr && (reg_addr == pdc_pkg::ADDR_CTRL);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_low <= pdc_pkg::RST_REF_LOW;
         ref_high <= pdc_pkg::RST_REF_HIGH;
      end else begin
         if (wr_ref_low) begin
            ref_low <= reg_wdata;
         end
         if (wr_ref_high) begin
            ref_high <= reg_wdata[5:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swallow_count <= pdc_pkg::RST_SWALLOW;
         main_count_low <= pdc_pkg::RST_MAIN_LOW;
         main_count_high <= pdc_pkg::RST_MAIN_HIGH;
      end else begin
         if (wr_swallow) begin
            swallow_count <= reg_wdata[5:0];
         end
         if (wr_main_low) begin
            main_count_low <= reg_wdata;
         end
         if (wr_main_high) begin
            main_count_high <= reg_wdata[4:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divider_control <= pdc_pkg::pdc_ctrl_t'(pdc_pkg::RST_CTRL);
      end else if (wr_ctrl) begin
         divider_control <= pdc_pkg::pdc_ctrl_t'(reg_wdata);
      end
   end

   // Read path: unused bits and unmapped addresses read zero
   assign rd_mux = (reg_addr == pdc_pkg::ADDR_REF_LOW) ? ref_low :
                   (reg_addr == pdc_pkg::ADDR_REF_HIGH) ? {2'h0, ref_high} :
                   (reg_addr == pdc_pkg::ADDR_SWALLOW) ? {2'h0, swallow_count} :
                   (reg_addr == pdc_pkg::ADDR_MAIN_LOW) ? main_count_low :
                   (reg_addr == pdc_pkg::ADDR_MAIN_HIGH) ? {3'h0, main_count_high} :
                   (reg_addr == pdc_pkg::ADDR_CTRL) ? 8'(divider_control) : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // Counter settings and holds
   logic [13:0] ref_load;
   logic [12:0] main_load;
   logic ref_hold;
   logic fb_hold;

   assign ref_load = {ref_high, ref_low};
   // Bypass loads one so every prescaler cycle ends a feedback cycle
   assign main_load = divider_control.main_bypass ? 13'h0001 :
                      {main_count_high, main_count_low};
   assign ref_hold = divider_control.rst_ref || divider_control.rst_all;
   assign fb_hold = divider_control.rst_fb || divider_control.rst_all;

   assign charge_pump_output_half = divider_control.cp_half;
   assign ref_div_held = ref_hold;
   assign fb_div_held = fb_hold;

   // Reference divider
   pdc_divcount #(
      .W(pdc_pkg::REF_W)
   ) u_ref_div (
      .clk(clk),
      .rst_n(rst_n),
      .hold(ref_hold),
      .tick(ref_tick),
      .load(ref_load),
      .count(),
      .done(ref_div_tick)
   );

   // Feedback prescaler
   logic swallow_active;
   logic [5:0] swallow_left;
   logic [12:0] main_left;
   logic main_end;

   pdc_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .hold(fb_hold),
      .osc_tick(osc_tick),
      .mode(divider_control.pre_mode),
      .swallow_active(swallow_active),
      .fixed_divide_mode(fixed_divide_mode),
      .dual_modulus_mode(dual_modulus_mode),
      .pre_tick(prescaler_tick)
   );

   // Main feedback counter, advanced by prescaler output
   pdc_divcount #(
      .W(pdc_pkg::MAIN_W)
   ) u_main_div (
      .clk(clk),
      .rst_n(rst_n),
      .hold(fb_hold),
      .tick(prescaler_tick),
      .load(main_load),
      .count(main_left),
      .done()
   );

   // Swallow counter: in dual-modulus modes prescaler runs at P+1 until it has counted A cycles
   assign main_end = (main_left <= 13'h0001);
   assign swallow_active = (swallow_left != 6'h00) && !divider_control.main_bypass;

   // Bypass acts at once, so a stale main count cannot delay the first feedback pulse
   logic next_fb_div_tick;
   assign next_fb_div_tick = prescaler_tick && (main_end || divider_control.main_bypass);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fb_div_tick <= 1'b0;
      end else if (fb_hold) begin
         fb_div_tick <= 1'b0;
      end else begin
         fb_div_tick <= next_fb_div_tick;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swallow_left <= 6'h00;
      end else if (fb_hold) begin
         swallow_left <= 6'h00;
      end else if (prescaler_tick) begin
         swallow_left <= main_end ? swallow_count : swallow_left - {5'h00, swallow_active};
      end
   end

   // Checks
   property p_cp_half;
      @(posedge clk) disable iff (!rst_n)
      wr_ctrl |=> (charge_pump_output_half == $past(reg_wdata[7]));
   endproperty
   a_cp_half: assert property (p_cp_half) else $error("pump mid-supply force wrong");

   property p_ref_hold;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.rst_ref && !wr_ctrl) |=> !ref_div_tick;
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("reference divider ran in hold");

   property p_fb_hold;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.rst_fb && !wr_ctrl) |=> (!fb_div_tick && !prescaler_tick);
   endproperty
   a_fb_hold: assert property (p_fb_hold) else $error("feedback divider ran in hold");

   property p_all_hold;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.rst_all && !wr_ctrl) |=> (!fb_div_tick && !ref_div_tick);
   endproperty
   a_all_hold: assert property (p_all_hold) else $error("counter ran under collective hold");

   property p_ref_high_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == pdc_pkg::ADDR_REF_HIGH) |=> (reg_rdata[7:6] == 2'h0);
   endproperty
   a_ref_high_read: assert property (p_ref_high_read) else $error("ref high spare bits");

   property p_swallow_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == pdc_pkg::ADDR_SWALLOW && !reg_wr) |=>
         (reg_rdata == {2'h0, swallow_count});
   endproperty
   a_swallow_read: assert property (p_swallow_read) else $error("swallow readback wrong");

   property p_main_high_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == pdc_pkg::ADDR_MAIN_HIGH) |=> (reg_rdata[7:5] == 3'h0);
   endproperty
   a_main_high_read: assert property (p_main_high_read) else $error("main high spare bits");

   property p_bypass;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.main_bypass && !fb_hold && prescaler_tick && !wr_ctrl) |=> fb_div_tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not divide by one");

   property p_div1;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.pre_mode == pdc_pkg::PRE_FD1 && !fb_hold && osc_tick && !wr_ctrl)
         |=> prescaler_tick;
   endproperty
   a_div1: assert property (p_div1) else $error("prescaler code zero not divide by one");

   property p_fixed_codes;
      @(posedge clk) disable iff (!rst_n)
      (divider_control.pre_mode == pdc_pkg::PRE_FD2 ||
       divider_control.pre_mode == pdc_pkg::PRE_FD3)
         |-> (fixed_divide_mode && !dual_modulus_mode);
   endproperty
   a_fixed_codes: assert property (p_fixed_codes) else $error("fixed code flagged dual");

   property p_ref_low_write;
      @(posedge clk) disable iff (!rst_n)
      wr_ref_low |=> (ref_low == $past(reg_wdata));
   endproperty
   a_ref_low_write: assert property (p_ref_low_write) else $error("ref low write lost");

   property p_ref_high_write;
      @(posedge clk) disable iff (!rst_n)
      wr_ref_high |=> (ref_high == $past(reg_wdata[5:0]));
   endproperty
   a_ref_high_write: assert property (p_ref_high_write) else $error("ref high write lost");

   property p_swallow_write;
      @(posedge clk) disable iff (!rst_n)
      wr_swallow |=> (swallow_count == $past(reg_wdata[5:0]));
   endproperty
   a_swallow_write: assert property (p_swallow_write) else $error("swallow write lost");

   property p_main_low_write;
      @(posedge clk) disable iff (!rst_n)
      wr_main_low |=> (main_count_low == $past(reg_wdata));
   endproperty
   a_main_low_write: assert property (p_main_low_write) else $error("main low write lost");

   property p_mode_write;
      @(posedge clk) disable iff (!rst_n)
      wr_ctrl |=> (divider_control.pre_mode == $past(reg_wdata[2:0]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("prescaler code write lost");

   property p_fb_from_pre;
      @(posedge clk) disable iff (!rst_n)
      fb_div_tick |-> $past(prescaler_tick);
   endproperty
   a_fb_from_pre: assert property (p_fb_from_pre) else $error("fb tick without prescaler");

endmodule : pdc_pll_divider_config

// ==== pdc_pkg.sv ====
// Purpose: Shared constants and types for the PLL divider configuration block
// Assumes: Byte-wide registers at the device's own register addresses
// Notes: Reset values and prescaler codes live here only

package pdc_pkg;

   // Register address width and data width
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;

   // Register addresses
   localparam logic [9:0] ADDR_REF_LOW = 10'h011;
   localparam logic [9:0] ADDR_REF_HIGH = 10'h012;
   localparam logic [9:0] ADDR_SWALLOW = 10'h013;
   localparam logic [9:0] ADDR_MAIN_LOW = 10'h014;
   localparam logic [9:0] ADDR_MAIN_HIGH = 10'h015;
   localparam logic [9:0] ADDR_CTRL = 10'h016;

   // Counter widths
   localparam int REF_W = 14;
   localparam int SWALLOW_W = 6;
   localparam int MAIN_W = 13;
   localparam int REF_HIGH_W = 6;
   localparam int MAIN_HIGH_W = 5;
   localparam int PRE_CNT_W = 6;

   // Values after reset
   localparam logic [7:0] RST_REF_LOW = 8'h01;
   localparam logic [5:0] RST_REF_HIGH = 6'h00;
   localparam logic [5:0] RST_SWALLOW = 6'h00;
   localparam logic [7:0] RST_MAIN_LOW = 8'h03;
   localparam logic [4:0] RST_MAIN_HIGH = 5'h00;
   localparam logic [7:0] RST_CTRL = 8'h06;

   // Prescaler mode codes
   localparam logic [2:0] PRE_FD1 = 3'h0;
   localparam logic [2:0] PRE_FD2 = 3'h1;
   localparam logic [2:0] PRE_DM2 = 3'h2;
   localparam logic [2:0] PRE_DM4 = 3'h3;
   localparam logic [2:0] PRE_DM8 = 3'h4;
   localparam logic [2:0] PRE_DM16 = 3'h5;
   localparam logic [2:0] PRE_DM32 = 3'h6;
   localparam logic [2:0] PRE_FD3 = 3'h7;

   // Divider control register, bit 7 down to bit 0
   typedef struct packed {
      logic cp_half;
      logic rst_ref;
      logic rst_fb;
      logic rst_all;
      logic main_bypass;
      logic [2:0] pre_mode;
   } pdc_ctrl_t;

endpackage : pdc_pkg

// ==== pdc_divcount.sv ====
// Purpose: Reloadable down counter that pulses once per full count
// Assumes: tick is a one-cycle event in the clk domain
// Notes: A load of zero behaves as divide-by-one

`timescale 1ns/100ps

module pdc_divcount #(
   parameter int W = 14
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic hold,
   input wire logic tick,
   input wire logic [W-1:0] load,
   // Status
   output logic [W-1:0] count,
   output logic done
);

   logic at_end;
   logic [W-1:0] next_count;

   // Zero counts as end so that a counter freed from hold fires on its first tick
   assign at_end = (count <= W'(1));
   assign next_count = at_end ? load : count - W'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         done <= 1'b0;
      end else if (hold) begin
         count <= '0;
         done <= 1'b0;
      end else begin
         done <= tick && at_end;
         if (tick) begin
            count <= next_count;
         end
      end
   end

endmodule : pdc_divcount

// ==== pdc_prescaler.sv ====
// Purpose: Fixed or dual-modulus prescaler for the feedback divider
// Assumes: osc_tick is one cycle per oscillator edge
// Notes: Modulus is combinational, not registered; a change mid-cycle takes effect at once

`timescale 1ns/100ps

module pdc_prescaler (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic hold,
   input wire logic osc_tick,
   input wire logic [2:0] mode,
   input wire logic swallow_active,
   // Status
   output logic fixed_divide_mode,
   output logic dual_modulus_mode,
   output logic pre_tick
);

   logic [5:0] base;
   logic [5:0] modulus;
   logic [5:0] cnt;
   logic [5:0] cnt_inc;
   logic wrap;

   assign base = (mode == pdc_pkg::PRE_FD1) ? 6'h01 :
                 (mode == pdc_pkg::PRE_FD2) ? 6'h02 :
                 (mode == pdc_pkg::PRE_FD3) ? 6'h03 :
                 (mode == pdc_pkg::PRE_DM2) ? 6'h02 :
                 (mode == pdc_pkg::PRE_DM4) ? 6'h04 :
                 (mode == pdc_pkg::PRE_DM8) ? 6'h08 :
                 (mode == pdc_pkg::PRE_DM16) ? 6'h10 : 6'h20;
   assign dual_modulus_mode = (mode >= pdc_pkg::PRE_DM2) && (mode <= pdc_pkg::PRE_DM32);
   assign fixed_divide_mode = !dual_modulus_mode;
   // Extra count only while swallowing; a zero swallow count leaves the base ratio
   assign modulus = base + {5'h00, dual_modulus_mode && swallow_active};
   assign cnt_inc = cnt + 6'h01;
   assign wrap = (cnt_inc >= modulus);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         pre_tick <= 1'b0;
      end else if (hold) begin
         cnt <= '0;
         pre_tick <= 1'b0;
      end else begin
         pre_tick <= osc_tick && wrap;
         if (osc_tick) begin
            cnt <= wrap ? 6'h00 : cnt_inc;
         end
      end
   end

endmodule : pdc_prescaler

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the divider configuration block
// Assumes: Inputs change 1 ns after the rising edge; ticks held high every cycle
// Notes: Periods skip two pulses so counters leave their post-hold start state

`timescale 1ns/100ps

module tb_top;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic ref_tick = 1'b0;
   logic osc_tick = 1'b0;
   logic ref_div_tick, prescaler_tick, fb_div_tick;
   logic cp_half, ref_held, fb_held, fd_mode, dm_mode;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int per;
   int i;
   logic [7:0] rd;
   logic [9:0] ra [6] = '{10'h011, 10'h012, 10'h013, 10'h014, 10'h015, 10'h016};
   logic [7:0] rv [6] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
   logic [7:0] rm [6] = '{8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f, 8'hff};
   // Prescaler ratio per mode code with a zero swallow count
   int pre_ratio [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
   int ref_r [3] = '{5, 258, 1};

   pdc_pll_divider_config DUT (
      .clk(clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .ref_tick(ref_tick),
      .osc_tick(osc_tick),
      .ref_div_tick(ref_div_tick),
      .prescaler_tick(prescaler_tick),
      .fb_div_tick(fb_div_tick),
      .charge_pump_output_half(cp_half),
      .ref_div_held(ref_held),
      .fb_div_held(fb_held),
      .fixed_divide_mode(fd_mode),
      .dual_modulus_mode(dm_mode)
   );

   always #50 clk = ~clk;

   // Hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails = fails + 1;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd_reg

   task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg

   task automatic chk_bit(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_per(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         fails++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_per

   function automatic logic pick(input int sel);
      return (sel == 0) ? ref_div_tick : (sel == 1) ? prescaler_tick : fb_div_tick;
   endfunction : pick

   // Cycles between the second and third pulse seen; 400 means none came
   task automatic period(input int sel, output int n);
      int k;
      for (k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (pick(sel) !== 1'b1 && n < 400);
      end
   endtask : period

   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      ref_tick = 1'b1;
      osc_tick = 1'b1;
      chk_bit("cp_half", 1'b0, cp_half);
      chk_bit("dm_mode", 1'b1, dm_mode);
      for (i = 0; i < 6; i++) begin
         rd_reg(ra[i], rd);
         chk_reg("reset value", rv[i], rd);
      end
      for (i = 0; i < 6; i++) begin
         wr_reg(ra[i], 8'hff);
         rd_reg(ra[i], rd);
         chk_reg("used bits", rm[i], rd);
      end
      wr_reg(10'h010, 8'haa);
      rd_reg(10'h010, rd);
      chk_reg("unmapped", 8'h00, rd);
      // Small ratios so that quiet periods below come from the holds alone
      wr_reg(10'h013, 8'h00);
      wr_reg(10'h014, 8'h03);
      wr_reg(10'h015, 8'h00);
      wr_reg(10'h012, 8'h00);
      wr_reg(10'h011, 8'h01);
      // Each hold and pump bit alone
      for (i = 4; i < 8; i++) begin
         wr_reg(10'h016, 8'h06 | (8'h01 << i));
         chk_bit("cp_half", i == 7, cp_half);
         chk_bit("ref_held", i == 6 || i == 4, ref_held);
         chk_bit("fb_held", i == 5 || i == 4, fb_held);
      end
      wr_reg(10'h016, 8'h16);
      period(0, per);
      chk_per("ref quiet", 400, per);
      period(2, per);
      chk_per("fb quiet", 400, per);
      // Every mode code, swallow zero, main counter bypassed
      for (i = 0; i < 8; i++) begin
         wr_reg(10'h016, 8'h08 | 8'(i));
         chk_bit("fd_mode", i < 2 || i == 7, fd_mode);
         chk_bit("dm_mode", i >= 2 && i <= 6, dm_mode);
         period(1, per);
         chk_per("prescaler", pre_ratio[i], per);
         period(2, per);
         chk_per("fb bypass", pre_ratio[i], per);
      end
      // Dual modulus: feedback ratio P*B + A with B=3, A=1
      wr_reg(10'h013, 8'h01);
      for (i = 2; i < 7; i++) begin
         wr_reg(10'h016, 8'(i));
         period(2, per);
         chk_per("fb dual", pre_ratio[i] * 3 + 1, per);
      end
      for (i = 1; i < 8; i += 6) begin
         wr_reg(10'h016, 8'(i));
         period(2, per);
         chk_per("fb fixed", pre_ratio[i] * 3, per);
      end
      wr_reg(10'h016, 8'h0c);
      period(2, per);
      chk_per("bypass swallow", 8, per);
      wr_reg(10'h016, 8'h20);
      period(2, per);
      chk_per("fb held", 400, per);
      period(0, per);
      chk_per("ref free", 1, per);
      // Reference ratio across both bytes
      for (i = 0; i < 3; i++) begin
         wr_reg(10'h012, 8'(ref_r[i] >> 8));
         wr_reg(10'h011, 8'(ref_r[i]));
         period(0, per);
         chk_per("ref divide", ref_r[i], per);
      end
      wr_reg(10'h016, 8'h40);
      period(0, per);
      chk_per("ref held", 400, per);
      summarize();
   end
endmodule : tb_top
